// ---- src/dduc_core.sv ----
// Functional notes
// - Command 0101 loads the four-bit load mask.
// - Mask command ignores the frame address field.
// - All mask bits reset to zero.
// - Masked channel ignores a load pin falling edge.
// - Bit 3 masks channel B, bit 0 channel A.
// - Command 0001 writes input; DAC if pin low.
// - Command 0010 copies input into DAC register.
// - Command 0011 writes input and DAC register.
// - Load pin falling edge updates unmasked channels.
// - Load pin held low overrides the mask.
// - Hardware reset clears to zero or midscale.
// - After hardware reset, outputs hold cleared value.
// - No output update while hardware reset low.
// - Command 0110 returns to power-on reset code.
// - Load and reset pins ignored during power-on.
// - Power-up level from select pin, held until written.
// - Command 0111 bit 0 switches reference off.
// - Reference frame ignores address and upper data.
// - 24-bit frame acted on at frame sync rise.
// - Pin low during write updates on sync rise.
`timescale 1ns/1ps

module dduc_core
	import dduc_pkg::*;
#(
	parameter int POR_LEN = POR_CYCLES
) (
	// System clock and reset
	input  wire logic              mclk_i,
	input  wire logic              arst_n_i,
	// Serial link
	input  wire logic              sclk_i,
	input  wire logic              sync_n_i,
	input  wire logic              sdin_i,
	// Control pins
	input  wire logic              load_dac_n_i,
	input  wire logic              hw_reset_n_i,
	input  wire logic              power_up_level_select_i,
	// Converter state
	output logic [DATA_W-1:0]      dac_a_code_o,
	output logic [DATA_W-1:0]      dac_b_code_o,
	output logic [MASK_W-1:0]      channel_load_mask_o,
	output logic                   internal_ref_off_o,
	output logic                   por_busy_o
);

	// The power-on counter is sixteen bits wide; longer windows cannot be counted.
	if (POR_LEN < 1 || POR_LEN > 65535) begin : g_bad_por_len
		$error("POR_LEN out of range");
	end

	// ----------------------------------------------------------------
	// Link domain: shift register
	// ----------------------------------------------------------------
	// Bits enter on the falling serial clock while frame sync is low.
	// The clock is allowed to stop between frames, so nothing here
	// waits for an edge after the last bit: the word simply sits still
	// until the next frame, and the system side samples it once frame
	// sync has been seen high through its synchroniser.
	logic [FRAME_W-1:0] shift_ff;

	always_ff @(negedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_ff <= '0;
		end else if (!sync_n_i) begin
			shift_ff <= {shift_ff[FRAME_W-2:0], sdin_i};
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic       sync_hi_q_ff;
	logic       ld_q_ff;
	logic       sync_hi;
	logic       ld_n_s;
	logic       hw_rst_n_s;
	logic       lvl_sel_s;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_ff <= 4'hf;
			sync_ff <= 4'hf;
		end else begin
			meta_ff <= {power_up_level_select_i, hw_reset_n_i, load_dac_n_i, sync_n_i};
			sync_ff <= meta_ff;
		end
	end

	assign sync_hi    = sync_ff[0];
	assign ld_n_s     = sync_ff[1];
	assign hw_rst_n_s = sync_ff[2];
	assign lvl_sel_s  = sync_ff[3];

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_hi_q_ff <= 1'b1;
			ld_q_ff      <= 1'b1;
		end else begin
			sync_hi_q_ff <= sync_hi;
			ld_q_ff      <= ld_n_s;
		end
	end

	// ----------------------------------------------------------------
	// Frame capture
	// ----------------------------------------------------------------
	// The shift word crosses without a synchroniser of its own: it has
	// stood still since the last serial clock edge, and the frame event
	// fires only after frame sync has passed both synchroniser stages.
	logic        frame_ev;
	logic        ld_fall;
	dduc_frame_t frame;

	assign frame_ev = sync_hi && !sync_hi_q_ff;
	assign ld_fall  = ld_q_ff && !ld_n_s;
	assign frame    = dduc_frame_t'(shift_ff);

	// ----------------------------------------------------------------
	// Power-on window
	// ----------------------------------------------------------------
	// Pins are not trusted until the window closes; the output level
	// select is re-read every cycle of it so a slow strap settles.
	logic [15:0] por_cnt_ff;
	logic        por_busy_ff;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_cnt_ff  <= '0;
			por_busy_ff <= 1'b1;
		end else if (por_busy_ff) begin
			por_cnt_ff  <= por_cnt_ff + 16'h0001;
			por_busy_ff <= (por_cnt_ff != 16'(POR_LEN - 1));
		end
	end

	logic       blocked;
	logic       frame_ok;
	dduc_code_t clear_code;

	assign blocked    = por_busy_ff || !hw_rst_n_s;
	assign frame_ok   = frame_ev && !por_busy_ff;
	assign clear_code = lvl_sel_s ? CODE_MID : CODE_ZERO;

	// ----------------------------------------------------------------
	// Mask and reference setup
	// ----------------------------------------------------------------
	logic [MASK_W-1:0] mask_ff;
	logic              ref_off_ff;
	logic              soft_rst;

	assign soft_rst = frame_ok && frame.cmd == CMD_SOFT_RESET;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_ff <= MASK_RST;
		end else if (por_busy_ff || soft_rst) begin
			mask_ff <= MASK_RST;
		end else if (frame_ok && frame.cmd == CMD_LOAD_MASK) begin
			// Address is not looked at; the unused middle bits stay zero.
			mask_ff <= frame.data[MASK_W-1:0] & MASK_USED;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_off_ff <= REF_OFF_RST;
		end else if (por_busy_ff || soft_rst) begin
			ref_off_ff <= REF_OFF_RST;
		end else if (frame_ok && frame.cmd == CMD_REF_SETUP) begin
			ref_off_ff <= frame.data[REF_OFF_POS];
		end
	end

	// ----------------------------------------------------------------
	// Channel registers
	// ----------------------------------------------------------------
	dduc_code_t in_ff  [NUM_CH];
	dduc_code_t dac_ff [NUM_CH];

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		logic sel;
		logic wr_in;
		logic wr_dac;
		logic copy;

		assign sel    = frame_ok && frame.addr[CH_ADDR_POS[ch]];
		assign wr_in  = sel && (frame.cmd == CMD_WR_INPUT || frame.cmd == CMD_WR_UPD);
		// A low pin during the write updates the DAC whatever the mask.
		assign wr_dac = sel && (frame.cmd == CMD_WR_UPD
			|| (frame.cmd == CMD_WR_INPUT && !ld_n_s));
		assign copy   = (sel && frame.cmd == CMD_UPD_DAC)
			|| (ld_fall && !mask_ff[CH_MASK_POS[ch]]);

		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				in_ff[ch] <= CODE_ZERO;
			end else if (blocked || soft_rst) begin
				in_ff[ch] <= clear_code;
			end else if (wr_in) begin
				in_ff[ch] <= frame.data;
			end
		end

		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				dac_ff[ch] <= CODE_ZERO;
			end else if (blocked || soft_rst) begin
				dac_ff[ch] <= clear_code;
			end else if (wr_dac) begin
				dac_ff[ch] <= frame.data;
			end else if (copy) begin
				dac_ff[ch] <= in_ff[ch];
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign dac_a_code_o        = dac_ff[0];
	assign dac_b_code_o        = dac_ff[1];
	assign channel_load_mask_o = mask_ff;
	assign internal_ref_off_o  = ref_off_ff;
	assign por_busy_o          = por_busy_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence seq_frame(logic [CMD_W-1:0] c);
		frame_ok && !blocked && !soft_rst && frame.cmd == c;
	endsequence

	sequence seq_quiet;
		!ld_fall && !blocked;
	endsequence

	chk_mask_load: assert property (
		frame_ok && frame.cmd == CMD_LOAD_MASK
		|=> mask_ff == ($past(frame.data[MASK_W-1:0]) & MASK_USED) && mask_ff[2:1] == 2'b00)
		else $error("mask load wrong");

	chk_mask_clear: assert property (
		soft_rst |=> mask_ff == MASK_RST && ref_off_ff == REF_OFF_RST)
		else $error("soft reset left mask or reference");

	chk_masked_hold: assert property (
		ld_fall && mask_ff[3] && !frame_ok && !blocked |=> $stable(dac_ff[1]))
		else $error("masked channel B followed load pin");

	chk_fall_copy: assert property (
		ld_fall && !mask_ff[0] && !frame_ok && !blocked |=> dac_ff[0] == $past(in_ff[0]))
		else $error("load pin fall did not copy channel A");

	chk_write_hold: assert property (
		seq_frame(CMD_WR_INPUT) ##0 frame.addr[0] && ld_n_s ##0 seq_quiet
		|=> $stable(dac_ff[0]) && in_ff[0] == $past(frame.data))
		else $error("write input touched DAC with pin high");

	chk_write_low: assert property (
		seq_frame(CMD_WR_INPUT) ##0 frame.addr[CH_ADDR_POS[1]] && !ld_n_s
		|=> dac_ff[1] == $past(frame.data) && in_ff[1] == $past(frame.data))
		else $error("write input with pin low did not update DAC");

	chk_update_cmd: assert property (
		seq_frame(CMD_UPD_DAC) ##0 frame.addr[0]
		|=> dac_ff[0] == $past(in_ff[0]) && $stable(in_ff[0]))
		else $error("update command wrong");

	chk_write_update: assert property (
		seq_frame(CMD_WR_UPD) ##0 frame.addr[CH_ADDR_POS[1]]
		|=> dac_ff[1] == $past(frame.data) && in_ff[1] == $past(frame.data))
		else $error("write and update command wrong");

	chk_hw_reset: assert property (
		!hw_rst_n_s |=> dac_ff[0] == $past(clear_code) && dac_ff[1] == $past(clear_code))
		else $error("hardware reset did not clear outputs");

	chk_reset_hold: assert property (
		$rose(hw_rst_n_s) && !por_busy_ff ##1 !frame_ok [*2] |-> $stable(dac_ff[0]))
		else $error("output moved after reset release");

	chk_por_level: assert property (
		por_busy_ff ##1 por_busy_ff |-> dac_ff[0] == $past(clear_code) && mask_ff == MASK_RST)
		else $error("power-on level wrong");

	chk_ref_write: assert property (
		frame_ok && frame.cmd == CMD_REF_SETUP |=> ref_off_ff == $past(frame.data[REF_OFF_POS]))
		else $error("reference setup bit wrong");

	chk_frame_edge: assert property (
		frame_ev
		|-> $past(sync_n_i, 2) && !$past(sync_n_i, 3) ##1 !frame_ev)
		else $error("frame event not on sync rise");

	// ----------------------------------------------------------------
	// Checks: register steadiness, channel paths and clear levels
	// ----------------------------------------------------------------
	// The single-channel checks here watch the channel not covered above, so a swapped index in
	// the generate loop shows up on one side or the other.
	chk_mask_steady: assert property (
		!(frame_ok && frame.cmd == CMD_LOAD_MASK) && !soft_rst && !por_busy_ff
		|=> $stable(mask_ff))
		else $error("mask moved without a mask command");

	chk_ref_steady: assert property (
		!(frame_ok && frame.cmd == CMD_REF_SETUP) && !soft_rst && !por_busy_ff
		|=> $stable(ref_off_ff))
		else $error("reference bit moved without a setup command");

	chk_soft_codes: assert property (
		soft_rst
		|=> dac_ff[0] == $past(clear_code) && dac_ff[1] == $past(clear_code))
		else $error("soft reset did not restore the power-on code");

	chk_soft_inputs: assert property (
		soft_rst
		|=> in_ff[0] == $past(clear_code) && in_ff[1] == $past(clear_code))
		else $error("soft reset left an input register");

	chk_write_skip: assert property (
		seq_frame(CMD_WR_UPD) ##0 !frame.addr[CH_ADDR_POS[0]] && !ld_fall
		|=> $stable(dac_ff[0]) && $stable(in_ff[0]))
		else $error("unaddressed channel A changed on write and update");

	chk_input_only: assert property (
		seq_frame(CMD_WR_INPUT) ##0 frame.addr[CH_ADDR_POS[1]] && ld_n_s
		|=> $stable(dac_ff[1]) && in_ff[1] == $past(frame.data))
		else $error("write input touched channel B DAC with pin high");

	chk_both_update: assert property (
		seq_frame(CMD_WR_UPD) ##0 frame.addr[CH_ADDR_POS[0]]
		|=> dac_ff[0] == $past(frame.data) && in_ff[0] == $past(frame.data))
		else $error("write and update wrong on channel A");

	chk_update_b: assert property (
		seq_frame(CMD_UPD_DAC) ##0 frame.addr[CH_ADDR_POS[1]]
		|=> dac_ff[1] == $past(in_ff[1]) && $stable(in_ff[1]))
		else $error("update command wrong on channel B");

	chk_fall_copy_b: assert property (
		ld_fall && !mask_ff[CH_MASK_POS[1]] && !frame_ok && !blocked
		|=> dac_ff[1] == $past(in_ff[1]))
		else $error("load pin fall did not copy channel B");

	chk_masked_hold_a: assert property (
		ld_fall && mask_ff[CH_MASK_POS[0]] && !frame_ok && !blocked
		|=> $stable(dac_ff[0]))
		else $error("masked channel A followed load pin");

	chk_hw_zero: assert property (
		!hw_rst_n_s && !lvl_sel_s
		|=> dac_ff[0] == CODE_ZERO && dac_ff[1] == CODE_ZERO)
		else $error("hardware reset did not clear to zero scale");

	chk_por_mid: assert property (
		por_busy_ff && lvl_sel_s
		|=> dac_ff[0] == CODE_MID && dac_ff[1] == CODE_MID)
		else $error("power-on level not midscale");

	chk_hw_inputs: assert property (
		!hw_rst_n_s
		|=> in_ff[0] == $past(clear_code) && in_ff[1] == $past(clear_code))
		else $error("hardware reset left an input register");

endmodule : dduc_core

// ---- src/dduc_pkg.sv ----
package dduc_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_W  = 24;
	localparam int CMD_W    = 4;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int NUM_CH   = 2;
	localparam int MASK_W   = 4;

	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dduc_frame_t;

	typedef logic [DATA_W-1:0] dduc_code_t;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [CMD_W-1:0] CMD_WR_INPUT   = 4'h1;
	localparam logic [CMD_W-1:0] CMD_UPD_DAC    = 4'h2;
	localparam logic [CMD_W-1:0] CMD_WR_UPD     = 4'h3;
	localparam logic [CMD_W-1:0] CMD_LOAD_MASK  = 4'h5;
	localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 4'h6;
	localparam logic [CMD_W-1:0] CMD_REF_SETUP  = 4'h7;

	// ----------------------------------------------------------------
	// Field positions: channel A is index 0, channel B is index 1
	// ----------------------------------------------------------------
	localparam int CH_ADDR_POS [NUM_CH] = '{0, 3};
	localparam int CH_MASK_POS [NUM_CH] = '{0, 3};
	localparam int REF_OFF_POS          = 0;

	// ----------------------------------------------------------------
	// Reset values and clear codes
	// ----------------------------------------------------------------
	localparam logic [MASK_W-1:0] MASK_RST       = 4'h0;
	localparam logic [MASK_W-1:0] MASK_USED      = 4'h9;
	localparam logic              REF_OFF_RST    = 1'b0;
	localparam dduc_code_t        CODE_ZERO      = 16'h0000;
	localparam dduc_code_t        CODE_MID       = 16'h8000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int POR_TIME_NS    = 320;
	localparam int POR_CYCLES     = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : dduc_pkg

// ---- testbench/dduc_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------
// Host serial master, clock runs only in frames
// ------------------------------------------
module dduc_host_model
	import dduc_pkg::*;
(
	// Serial link
	output logic sclk_o,
	output logic sync_n_o,
	output logic sdin_o
);
	initial begin
		sclk_o = 1'b1;
		sync_n_o = 1'b1;
		sdin_o = 1'b0;
	end
	// The released data line flips, so a sample taken late cannot match by luck.
	task automatic send(input dduc_frame_t f);
		// Step off the system clock edge so the synchroniser never races the fall.
		#1;
		sync_n_o = 1'b0;
		for (int i = FRAME_W - 1; i >= 0; i--) begin
			sdin_o = f[i];
			#24 sclk_o = 1'b0;
			#24 sclk_o = 1'b1;
		end
		#24 sync_n_o = 1'b1;
		sdin_o = ~sdin_o;
		#30;
	endtask : send
endmodule : dduc_host_model

// ---- testbench/dual_dac_update_reset_control_tb_top.sv ----
`timescale 1ns/1ps
module dual_dac_update_reset_control_tb_top
	import dduc_pkg::*;
;
	logic        mclk_i;
	logic        arst_n_i;
	logic        sclk;
	logic        sync_n;
	logic        sdin;
	logic        load_dac_n;
	logic        hw_reset_n;
	logic        sel;
	logic [15:0] dac_a;
	logic [15:0] dac_b;
	logic [3:0]  mask;
	logic        ref_off;
	logic        por_busy;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	localparam int POR_LEN_TB = 4;

	dduc_host_model dduc_host_model_i (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin));
	dduc_core #(.POR_LEN(POR_LEN_TB)) dduc_core_i (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .sync_n_i(sync_n),
		.sdin_i(sdin), .load_dac_n_i(load_dac_n), .hw_reset_n_i(hw_reset_n),
		.power_up_level_select_i(sel), .dac_a_code_o(dac_a), .dac_b_code_o(dac_b),
		.channel_load_mask_o(mask), .internal_ref_off_o(ref_off), .por_busy_o(por_busy)
	);

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// ------------------------------------------
	// Shared tasks
	// ------------------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic codes(input logic [15:0] ea, input logic [15:0] eb);
		chk("dac_a", ea, dac_a);
		chk("dac_b", eb, dac_b);
	endtask : codes

	// Eight cycles covers the three-cycle answer plus phase slack.
	task automatic frm(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		dduc_host_model_i.send({c, a, d});
		repeat (8) @(posedge mclk_i);
	endtask : frm

	task automatic pin(input logic v);
		@(posedge mclk_i);
		load_dac_n <= v;
		repeat (8) @(posedge mclk_i);
	endtask : pin

	// ------------------------------------------
	// Scenarios
	// ------------------------------------------
	// Outputs are read at the falling edge, where they have settled.
	task automatic t_power_up();
		repeat (POR_LEN_TB - 1) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("por_busy", 16'h0001, {15'h0000, por_busy});
		@(posedge mclk_i);
		@(negedge mclk_i);
		chk("por_busy", 16'h0000, {15'h0000, por_busy});
		codes(CODE_MID, CODE_MID);
		chk("mask", 16'h0000, {12'h000, mask});
		chk("ref_off", 16'h0000, {15'h0000, ref_off});
	endtask : t_power_up

	task automatic t_write();
		frm(CMD_WR_UPD, 4'h1, 16'h1234);
		codes(16'h1234, CODE_MID);
		frm(CMD_WR_UPD, 4'h8, 16'habcd);
		codes(16'h1234, 16'habcd);
		frm(CMD_WR_INPUT, 4'h9, 16'h5555);
		codes(16'h1234, 16'habcd);
		pin(1'b0);
		codes(16'h5555, 16'h5555);
		pin(1'b1);
	endtask : t_write

	task automatic t_copy();
		frm(CMD_WR_INPUT, 4'h9, 16'h0f0f);
		frm(CMD_UPD_DAC, 4'h1, 16'hffff);
		codes(16'h0f0f, 16'h5555);
		frm(CMD_UPD_DAC, 4'h8, 16'hffff);
		codes(16'h0f0f, 16'h0f0f);
		pin(1'b0);
		codes(16'h0f0f, 16'h0f0f);
		pin(1'b1);
	endtask : t_copy

	task automatic t_mask();
		frm(CMD_LOAD_MASK, 4'h0, 16'hffff);
		chk("mask", 16'h0009, {12'h000, mask});
		frm(CMD_LOAD_MASK, 4'h6, 16'h0001);
		chk("mask", 16'h0001, {12'h000, mask});
		frm(CMD_WR_INPUT, 4'h1, 16'h1111);
		frm(CMD_WR_INPUT, 4'h8, 16'h2222);
		pin(1'b0);
		codes(16'h0f0f, 16'h2222);
		pin(1'b1);
		frm(CMD_LOAD_MASK, 4'h0, 16'h0008);
		pin(1'b0);
		frm(CMD_WR_INPUT, 4'h8, 16'h4444);
		codes(16'h1111, 16'h4444);
		pin(1'b1);
	endtask : t_mask

	// The clear pin is held eight cycles before the first check, above the three the core needs.
	task automatic t_hw();
		@(posedge mclk_i);
		sel <= 1'b0;
		hw_reset_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		codes(CODE_ZERO, CODE_ZERO);
		frm(CMD_WR_UPD, 4'h1, 16'h7777);
		codes(CODE_ZERO, CODE_ZERO);
		hw_reset_n <= 1'b1;
		repeat (8) @(posedge mclk_i);
		codes(CODE_ZERO, CODE_ZERO);
	endtask : t_hw

	task automatic t_soft();
		frm(CMD_WR_UPD, 4'h9, 16'h6666);
		codes(16'h6666, 16'h6666);
		sel <= 1'b1;
		frm(CMD_SOFT_RESET, 4'h0, 16'h0000);
		codes(CODE_MID, CODE_MID);
		chk("mask", 16'h0000, {12'h000, mask});
	endtask : t_soft

	task automatic t_ref();
		frm(CMD_REF_SETUP, 4'hf, 16'hfffe);
		chk("ref_off", 16'h0000, {15'h0000, ref_off});
		frm(CMD_REF_SETUP, 4'hf, 16'h0001);
		chk("ref_off", 16'h0001, {15'h0000, ref_off});
		frm(CMD_REF_SETUP, 4'h0, 16'h0000);
		chk("ref_off", 16'h0000, {15'h0000, ref_off});
	endtask : t_ref

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		arst_n_i = 1'b0;
		load_dac_n = 1'b1;
		hw_reset_n = 1'b1;
		sel = 1'b1;
		repeat (20) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_power_up();
		t_write();
		t_copy();
		t_mask();
		t_hw();
		t_soft();
		t_ref();
		conclude();
	end
endmodule : dual_dac_update_reset_control_tb_top
